/* rtl/tunnel_fwd_consts.vh */
`ifndef TUNNEL_FWD_CONSTS_VH
`define TUNNEL_FWD_CONSTS_VH
`define ETYPE_IP 16'h0800
`define ETYPE_HI_OFF 8'h0C
`define ETYPE_LO_OFF 8'h0D
`define IP_VER_OFF 8'h0E
`define IP_PROTO_OFF 8'h17
`define IP_CSUM_HI_OFF 8'h18
`define IP_CSUM_LO_OFF 8'h19
`define IP_SRC_OFF 8'h1A
`define IP_DST_OFF 8'h1E
`define IP_HDR_END 8'h22
`define PROTO_UDP 8'h11
`define PROTO_GRE 8'h2F
`define GRE_HDR_LEN 8'h18
`define UDP_DPORT_OFF 8'h24
`define FC_PACKET_PDU 8'hC0
`define MCAST_PREFIX 4'hE
`define NUM_TUNNELS 32
`define NUM_CHANNELS 4
`define TOKEN_W 16
`endif

/* rtl/tunnel_rate_meter.v */
`timescale 1ns/1ns
`include "tunnel_fwd_consts.vh"
module tunnel_rate_meter #(
    parameter N = `NUM_TUNNELS,
    parameter TW = `TOKEN_W
) (
    input wire clk,
    input wire rst_n,
    input wire [N*TW-1:0] rate,
    input wire [N*TW-1:0] burst,
    input wire [4:0] idx,
    input wire consume,
    output wire allow
);
    reg [TW-1:0] bucket_r [0:N-1];
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : gen_bkt
            wire [TW:0] sum = {1'b0, bucket_r[g]} + {1'b0, rate[g*TW +: TW]};
            wire [TW-1:0] cap = burst[g*TW +: TW];
            wire [TW-1:0] fill = (sum > {1'b0, cap}) ? cap : sum[TW-1:0];
            wire take = consume && (idx == g) && (bucket_r[g] != {TW{1'b0}});
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    bucket_r[g] <= {TW{1'b0}};
                end else if (take) begin
                    bucket_r[g] <= bucket_r[g] - 1'b1;
                end else begin
                    bucket_r[g] <= fill;
                end
            end
        end
    endgenerate
    assign allow = (bucket_r[idx] != {TW{1'b0}});
endmodule

/* rtl/tunnel_map_table.v */
`timescale 1ns/1ns
`include "tunnel_fwd_consts.vh"
module tunnel_map_table #(
    parameter N = `NUM_TUNNELS
) (
    input wire clk,
    input wire rst_n,
    input wire cfg_we,
    input wire [4:0] cfg_idx,
    input wire cfg_valid,
    input wire [31:0] cfg_group,
    input wire [47:0] cfg_mac,
    input wire [`NUM_CHANNELS-1:0] cfg_chans,
    input wire [31:0] lookup_ip,
    output reg hit,
    output reg [4:0] hit_idx,
    output reg [47:0] hit_mac,
    output reg [`NUM_CHANNELS-1:0] hit_chans,
    output reg cfg_reject
);
    reg valid_r [0:N-1];
    reg [31:0] group_r [0:N-1];
    reg [47:0] mac_r [0:N-1];
    reg [`NUM_CHANNELS-1:0] chans_r [0:N-1];
    reg dup;
    integer i;
    always @* begin
        dup = 1'b0;
        for (i = 0; i < N; i = i + 1) begin
            if (valid_r[i] && group_r[i] == cfg_group && i != cfg_idx && mac_r[i] != cfg_mac)
                dup = 1'b1;
        end
    end
    always @* begin
        hit = 1'b0;
        hit_idx = 5'h00;
        hit_mac = 48'h000000000000;
        hit_chans = {`NUM_CHANNELS{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (valid_r[i] && group_r[i] == lookup_ip) begin
                hit = 1'b1;
                hit_idx = i[4:0];
                hit_mac = mac_r[i];
                hit_chans = chans_r[i];
            end
        end
    end
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : gen_ent
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    valid_r[g] <= 1'b0;
                    group_r[g] <= 32'h00000000;
                    mac_r[g] <= 48'h000000000000;
                    chans_r[g] <= {`NUM_CHANNELS{1'b0}};
                end else if (cfg_we && cfg_idx == g && !(cfg_valid && (dup || !cfg_mac[40]))) begin
                    valid_r[g] <= cfg_valid;
                    group_r[g] <= cfg_group;
                    mac_r[g] <= cfg_mac;
                    chans_r[g] <= cfg_chans;
                end
            end
        end
    endgenerate
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reject <= 1'b0;
        end else begin
            cfg_reject <= cfg_we && cfg_valid && (dup || !cfg_mac[40]);
        end
    end
endmodule

/* rtl/oob_tunnel_forwarder.v */
// Notes on behaviour
// - drop frames whose ethertype is not IP
// - strip GRE wrapping, filter port and protocol
// - port filter admits only, never selects tunnel
// - optional trusted source address check
// - downstream only, no return path needed
// - forward on one or many channels
// - legacy and table-driven receivers together
// - frame control set to packet PDU
// - management messages never to tunnel MAC
// - thirty-two tunnels per channel; the map table holds thirty-two in total, shared by all channels
// - per-tunnel rate limit, descriptors unmetered
// - rewrite destination and source MAC
// - keep IP addresses and protocol, bar translated destination
// - payload passes bit exact
// - TTL and checksum may change
// - group to tunnel map, reject a group already mapped to another MAC
// - unicast-wrapped multicast stripped then classified
// - unicast destination translated to multicast
// - plain unicast forwarded by unicast destination
// - tunnel MAC must be group address
`timescale 1ns/1ns
`include "tunnel_fwd_consts.vh"
module oob_tunnel_forwarder #(
    parameter N = `NUM_TUNNELS,
    parameter TW = `TOKEN_W
) (
    // clock and reset
    input wire CORE_CLK,
    input wire ARST_N,
    // configuration
    input wire [47:0] HFC_MAC,
    input wire SRC_CHECK_EN,
    input wire [31:0] TRUSTED_SRC,
    input wire [15:0] ADMIT_PORT,
    input wire [7:0] ADMIT_PROTO,
    input wire [1:0] UNICAST_METHOD,
    input wire [31:0] XLATE_UCAST,
    input wire [31:0] XLATE_MCAST,
    input wire MAP_WE,
    input wire [4:0] MAP_IDX,
    input wire MAP_VALID,
    input wire [31:0] MAP_GROUP,
    input wire [47:0] MAP_MAC,
    input wire [`NUM_CHANNELS-1:0] MAP_CHANS,
    input wire [N*TW-1:0] RATE_CFG,
    input wire [N*TW-1:0] BURST_CFG,
    // network side byte stream
    input wire IN_VALID,
    input wire [7:0] IN_DATA,
    input wire IN_SOF,
    input wire IN_EOF,
    // downstream byte stream
    output reg OUT_VALID,
    output reg [7:0] OUT_DATA,
    output reg OUT_SOF,
    output reg OUT_EOF,
    output reg [`NUM_CHANNELS-1:0] OUT_CHANS,
    output reg OUT_DROP,
    output reg MAP_REJECT
);
    localparam ST_HDR = 2'b00;
    localparam ST_SEND = 2'b01;
    localparam ST_SKIP = 2'b10;
    localparam MAXB = 256;

    reg rs1_r, rs2_r;
    wire rst_n = rs2_r;
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end

    // whole frame is held, then classified at end of frame
    reg [7:0] buf_r [0:MAXB-1];
    reg [7:0] wptr_r, len_r, rptr_r, base_r;
    reg [1:0] state_r;
    reg [47:0] dmac_r;
    reg [`NUM_CHANNELS-1:0] chans_r;
    reg [4:0] tidx_r;
    reg xlate_r;
    reg [7:0] off;
    reg [15:0] etype, dport;
    reg [7:0] proto, iproto, prot_use;
    reg [31:0] src, dst, dst_use;
    reg gre, admit, is_mcast;
    wire hit, allow;
    wire [4:0] hit_idx;
    wire [47:0] hit_mac;
    wire [`NUM_CHANNELS-1:0] hit_chans;
    wire map_rej;

    tunnel_map_table #(.N(N)) u_map (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .cfg_we(MAP_WE),
        .cfg_idx(MAP_IDX),
        .cfg_valid(MAP_VALID),
        .cfg_group(MAP_GROUP),
        .cfg_mac(MAP_MAC),
        .cfg_chans(MAP_CHANS),
        .lookup_ip(dst_use),
        .hit(hit),
        .hit_idx(hit_idx),
        .hit_mac(hit_mac),
        .hit_chans(hit_chans),
        .cfg_reject(map_rej)
    );

    wire frame_end = IN_VALID && IN_EOF && state_r == ST_HDR;
    wire fwd = frame_end && admit && hit && allow;

    tunnel_rate_meter #(.N(N), .TW(TW)) u_meter (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .rate(RATE_CFG),
        .burst(BURST_CFG),
        .idx(hit_idx),
        .consume(fwd),
        .allow(allow)
    );

    always @(posedge CORE_CLK) begin
        if (IN_VALID && state_r == ST_HDR)
            buf_r[IN_SOF ? 8'h00 : wptr_r] <= IN_DATA;
    end

    // parse: outer header, optional GRE-wrapped inner header
    always @* begin
        etype = {buf_r[`ETYPE_HI_OFF], buf_r[`ETYPE_LO_OFF]};
        proto = buf_r[`IP_PROTO_OFF];
        gre = (proto == `PROTO_GRE) && (UNICAST_METHOD == 2'b01);
        off = gre ? `GRE_HDR_LEN : 8'h00;
        iproto = buf_r[`IP_PROTO_OFF + off];
        src = {buf_r[`IP_SRC_OFF + off], buf_r[`IP_SRC_OFF + off + 8'h01],
               buf_r[`IP_SRC_OFF + off + 8'h02], buf_r[`IP_SRC_OFF + off + 8'h03]};
        dst = {buf_r[`IP_DST_OFF + off], buf_r[`IP_DST_OFF + off + 8'h01],
               buf_r[`IP_DST_OFF + off + 8'h02], buf_r[`IP_DST_OFF + off + 8'h03]};
        dport = {buf_r[`UDP_DPORT_OFF + off], buf_r[`UDP_DPORT_OFF + off + 8'h01]};
        prot_use = iproto;
        is_mcast = (dst[31:28] == `MCAST_PREFIX);
        // unicast translated to its configured group
        dst_use = (UNICAST_METHOD == 2'b10 && dst == XLATE_UCAST) ? XLATE_MCAST : dst;
        admit = (etype == `ETYPE_IP)
            && (prot_use == ADMIT_PROTO)
            && (prot_use != `PROTO_UDP || dport == ADMIT_PORT)
            && (!SRC_CHECK_EN || src == TRUSTED_SRC)
            && (is_mcast || UNICAST_METHOD != 2'b00 || dst_use != dst);
    end

    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_HDR;
            wptr_r <= 8'h00;
            len_r <= 8'h00;
            rptr_r <= 8'h00;
            base_r <= 8'h00;
            dmac_r <= 48'h000000000000;
            chans_r <= {`NUM_CHANNELS{1'b0}};
            tidx_r <= 5'h00;
            xlate_r <= 1'b0;
            OUT_VALID <= 1'b0;
            OUT_DATA <= 8'h00;
            OUT_SOF <= 1'b0;
            OUT_EOF <= 1'b0;
            OUT_CHANS <= {`NUM_CHANNELS{1'b0}};
            OUT_DROP <= 1'b0;
            MAP_REJECT <= 1'b0;
        end else begin
            MAP_REJECT <= map_rej;
            OUT_DROP <= 1'b0;
            OUT_VALID <= 1'b0;
            OUT_SOF <= 1'b0;
            OUT_EOF <= 1'b0;
            case (state_r)
                ST_HDR: begin
                    if (IN_VALID) begin
                        wptr_r <= IN_SOF ? 8'h01 : wptr_r + 8'h01;
                        if (IN_EOF) begin
                            if (fwd) begin
                                // never blocked by a return path
                                state_r <= ST_SEND;
                                len_r <= wptr_r + 8'h01;
                                rptr_r <= 8'h00;
                                base_r <= off;
                                dmac_r <= hit_mac;
                                chans_r <= hit_chans;
                                tidx_r <= hit_idx;
                                xlate_r <= (dst_use != dst);
                            end else begin
                                OUT_DROP <= 1'b1;
                            end
                        end
                    end
                end
                ST_SEND: begin
                    // leading byte is frame control
                    OUT_VALID <= 1'b1;
                    OUT_CHANS <= chans_r;
                    OUT_SOF <= (rptr_r == 8'h00);
                    if (rptr_r == 8'h00)
                        OUT_DATA <= `FC_PACKET_PDU;
                    else if (rptr_r <= 8'h06)
                        OUT_DATA <= dmac_r[(8'h06 - rptr_r) * 8 +: 8];
                    else if (rptr_r <= 8'h0C)
                        OUT_DATA <= HFC_MAC[(8'h0C - rptr_r) * 8 +: 8];
                    else if (rptr_r <= 8'h0E)
                        OUT_DATA <= buf_r[rptr_r - 8'h01];
                    else if (xlate_r && rptr_r > `IP_DST_OFF + base_r
                             && rptr_r <= `IP_DST_OFF + base_r + 8'h04)
                        OUT_DATA <= dst_use_byte(rptr_r - `IP_DST_OFF - base_r - 8'h01);
                    else if (xlate_r && (rptr_r == `IP_CSUM_HI_OFF + base_r + 8'h01
                             || rptr_r == `IP_CSUM_LO_OFF + base_r + 8'h01))
                        OUT_DATA <= 8'h00;
                    else
                        OUT_DATA <= buf_r[rptr_r - 8'h01 + base_r];
                    rptr_r <= rptr_r + 8'h01;
                    if (rptr_r + base_r == len_r) begin
                        OUT_EOF <= 1'b1;
                        state_r <= ST_HDR;
                    end
                end
                default: begin
                    state_r <= ST_HDR;
                end
            endcase
        end
    end

    function [7:0] dst_use_byte;
        input [7:0] k;
        begin
            dst_use_byte = XLATE_MCAST[(8'h03 - k[1:0]) * 8 +: 8];
        end
    endfunction
endmodule

/* bench/oob_fwd_checker_assertions.sv */
`timescale 1ns/1ns
`include "tunnel_fwd_consts.vh"
module oob_fwd_checker (
    // clock and reset
    input wire CORE_CLK,
    input wire ARST_N,
    // watched ports
    input wire IN_VALID,
    input wire IN_EOF,
    input wire [47:0] HFC_MAC,
    input wire MAP_WE,
    input wire OUT_VALID,
    input wire [7:0] OUT_DATA,
    input wire OUT_SOF,
    input wire [`NUM_CHANNELS-1:0] OUT_CHANS,
    input wire OUT_DROP,
    input wire MAP_REJECT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    property p_fc; OUT_SOF |-> OUT_VALID && OUT_DATA == 8'hC0; endproperty
    a_fc: assert property (p_fc) else $error("bad frame control");
    property p_grp; OUT_SOF |=> OUT_DATA[0]; endproperty
    a_grp: assert property (p_grp) else $error("tunnel mac not group");
    property p_src;
        OUT_SOF |-> ##7 OUT_DATA == HFC_MAC[47:40] ##5 OUT_DATA == HFC_MAC[7:0];
    endproperty
    a_src: assert property (p_src) else $error("bad source mac");
    property p_et; OUT_SOF |-> ##13 OUT_DATA == 8'h08 ##1 OUT_DATA == 8'h00; endproperty
    a_et: assert property (p_et) else $error("bad ethertype");
    property p_gap; OUT_VALID && !OUT_SOF |-> $past(OUT_VALID); endproperty
    a_gap: assert property (p_gap) else $error("gap in pdu");
    property p_drop; OUT_DROP |-> !OUT_VALID ##1 !OUT_DROP; endproperty
    a_drop: assert property (p_drop) else $error("bad drop pulse");
    property p_ans; IN_VALID && IN_EOF && !OUT_VALID |-> ##[1:3] (OUT_SOF || OUT_DROP); endproperty
    a_ans: assert property (p_ans) else $error("no verdict");
    property p_chan; OUT_SOF |-> OUT_CHANS != 0; endproperty
    a_chan: assert property (p_chan) else $error("no channel");
    property p_rej; $rose(MAP_REJECT) |-> $past(MAP_WE) || $past(MAP_WE, 2); endproperty
    a_rej: assert property (p_rej) else $error("reject without write");
endmodule

bind oob_tunnel_forwarder oob_fwd_checker u_oob_fwd_checker (.CORE_CLK, .ARST_N, .IN_VALID,
    .IN_EOF, .HFC_MAC, .MAP_WE, .OUT_VALID, .OUT_DATA, .OUT_SOF, .OUT_CHANS, .OUT_DROP,
    .MAP_REJECT);

/* bench/server_model.sv */
`timescale 1ns/1ns
module server_model (
    // clock
    input wire clk,
    // network side stream
    output reg vld,
    output reg [7:0] dat,
    output reg sof,
    output reg eof
);
    reg [7:0] frm [0:255];
    integer i;
    initial begin
        vld = 1'b0;
        dat = 8'h00;
        sof = 1'b0;
        eof = 1'b0;
    end
    // whole short frame, bytes back to back
    task send(input integer len);
        begin
            for (i = 0; i < len; i = i + 1) begin
                @(posedge clk);
                vld <= 1'b1;
                dat <= frm[i];
                sof <= (i == 0);
                eof <= (i == len - 1);
            end
            @(posedge clk);
            vld <= 1'b0;
            eof <= 1'b0;
            dat <= ~dat;
        end
    endtask
endmodule

/* bench/tb_oob_tunnel_forwarder.sv */
`timescale 1ns/1ns
`include "tunnel_fwd_consts.vh"
module tb_oob_tunnel_forwarder;
    localparam [31:0] G0 = 32'hE0010101, G1 = 32'hEF000203, SRC = 32'h0A000001;
    localparam [47:0] M0 = 48'h01005E010101, M1 = 48'h03AB00000031;
    reg CORE_CLK = 0, ARST_N = 0, SRC_CHECK_EN = 0, MAP_WE = 0, MAP_VALID = 0;
    reg [47:0] HFC_MAC = 48'h02A5C3E17B01, MAP_MAC = 0;
    reg [31:0] TRUSTED_SRC = SRC, XLATE_UCAST = 32'h0A000005, XLATE_MCAST = G0, MAP_GROUP = 0;
    reg [15:0] ADMIT_PORT = 16'h2710;
    reg [7:0] ADMIT_PROTO = 8'h11;
    reg [1:0] UNICAST_METHOD = 0;
    reg [4:0] MAP_IDX = 0;
    reg [`NUM_CHANNELS-1:0] MAP_CHANS = 0, chs;
    reg [511:0] RATE_CFG = {32{16'h0080}}, BURST_CFG = {32{16'hFFFF}};
    wire IN_VALID, IN_SOF, IN_EOF, OUT_VALID, OUT_SOF, OUT_EOF, OUT_DROP, MAP_REJECT;
    wire [7:0] IN_DATA, OUT_DATA;
    wire [`NUM_CHANNELS-1:0] OUT_CHANS;
    integer err_total = 0, compares = 0, n, le;
    reg dr;
    reg [7:0] got [0:299];
    reg [7:0] f [0:59];
    oob_tunnel_forwarder u_oob_tunnel_forwarder (.CORE_CLK, .ARST_N, .HFC_MAC, .SRC_CHECK_EN,
        .TRUSTED_SRC, .ADMIT_PORT, .ADMIT_PROTO, .UNICAST_METHOD, .XLATE_UCAST, .XLATE_MCAST,
        .MAP_WE, .MAP_IDX, .MAP_VALID, .MAP_GROUP, .MAP_MAC, .MAP_CHANS, .RATE_CFG, .BURST_CFG,
        .IN_VALID, .IN_DATA, .IN_SOF, .IN_EOF, .OUT_VALID, .OUT_DATA, .OUT_SOF, .OUT_EOF,
        .OUT_CHANS, .OUT_DROP, .MAP_REJECT);
    server_model u_server_model (.clk(CORE_CLK), .vld(IN_VALID), .dat(IN_DATA), .sof(IN_SOF),
        .eof(IN_EOF));
    initial forever #20 CORE_CLK = ~CORE_CLK;
    task summarize;
        begin
            if (err_total == 0 && compares > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [47:0] g, input [47:0] e);
        begin
            compares = compares + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task mk(input [15:0] et, input [7:0] pr, input [31:0] s, input [31:0] d, input [15:0] dp);
        integer j;
        begin
            for (j = 0; j < 60; j = j + 1) f[j] = 8'(j * 7 + 3);
            {f[12], f[13]} = et;
            f[14] = 8'h45;
            f[23] = pr;
            {f[26], f[27], f[28], f[29]} = s;
            {f[30], f[31], f[32], f[33]} = d;
            {f[36], f[37]} = dp;
            for (j = 0; j < 60; j = j + 1) u_server_model.frm[j] = f[j];
            u_server_model.send(60);
        end
    endtask
    task recv;
        integer t;
        begin
            n = 0;
            le = 0;
            t = 0;
            @(negedge CORE_CLK);
            while (OUT_VALID !== 1'b1 && OUT_DROP !== 1'b1 && t < 40) begin
                @(negedge CORE_CLK);
                t = t + 1;
            end
            dr = OUT_DROP;
            chs = OUT_CHANS;
            while (OUT_VALID === 1'b1 && n < 300) begin
                got[n] = OUT_DATA;
                if (OUT_EOF === 1'b1)
                    le = n;
                n = n + 1;
                @(negedge CORE_CLK);
            end
        end
    endtask
    task drop;
        begin
            recv;
            chk(dr, 1);
        end
    endtask
    task fwd(input [47:0] mac, input [`NUM_CHANNELS-1:0] ch, input [31:0] dip);
        integer k;
        reg [7:0] e;
        begin
            recv;
            chk(n, 61);
            chk(le, 60);
            chk(chs, ch);
            chk(got[0], 8'hC0);
            chk({got[1], got[2], got[3], got[4], got[5], got[6]}, mac);
            chk({got[7], got[8], got[9], got[10], got[11], got[12]}, HFC_MAC);
            chk({got[13], got[14]}, 16'h0800);
            for (k = 15; k < 61; k = k + 1) begin
                e = (k >= 31 && k < 35) ? dip[8 * (34 - k) +: 8] : f[k - 1];
                if (k != 23 && k != 25 && k != 26) chk(got[k], e);
            end
        end
    endtask
    task mapw(input [4:0] i, input [31:0] g, input [47:0] m, input [3:0] c, input rej);
        reg seen;
        begin
            @(posedge CORE_CLK);
            MAP_WE <= 1'b1;
            MAP_IDX <= i;
            MAP_VALID <= 1'b1;
            MAP_GROUP <= g;
            MAP_MAC <= m;
            MAP_CHANS <= c;
            @(posedge CORE_CLK);
            MAP_WE <= 1'b0;
            seen = 0;
            repeat (3) begin
                @(negedge CORE_CLK);
                seen = seen | MAP_REJECT;
            end
            chk(seen, rej);
        end
    endtask
    task t_map;
        begin
            mapw(0, G0, M0, 4'h3, 0);
            mapw(1, G0, M1, 4'h4, 1);
            mapw(2, G1, 48'h020000000002, 4'h1, 1);
            mapw(31, G1, M1, 4'hC, 0);
            mapw(3, 32'h0A000007, 48'h010000000007, 4'h2, 0);
        end
    endtask
    task t_fwd;
        begin
            mk(16'h0800, 8'h11, SRC, G0, 16'h2710);
            fwd(M0, 4'h3, G0);
            mk(16'h0800, 8'h11, SRC, G1, 16'h2710);
            fwd(M1, 4'hC, G1);
        end
    endtask
    task t_filt;
        begin
            mk(16'h86DD, 8'h11, SRC, G0, 16'h2710);
            drop;
            mk(16'h0800, 8'h11, SRC, G0, 16'h2711);
            drop;
            mk(16'h0800, 8'h06, SRC, G0, 16'h2710);
            drop;
            mk(16'h0800, 8'h11, SRC, 32'hE0000009, 16'h2710);
            drop;
        end
    endtask
    task t_src;
        begin
            @(posedge CORE_CLK);
            SRC_CHECK_EN <= 1'b1;
            mk(16'h0800, 8'h11, 32'h0A000002, G0, 16'h2710);
            drop;
            mk(16'h0800, 8'h11, SRC, G0, 16'h2710);
            fwd(M0, 4'h3, G0);
            SRC_CHECK_EN <= 1'b0;
        end
    endtask
    task t_xlate;
        begin
            @(posedge CORE_CLK);
            UNICAST_METHOD <= 2'd2;
            mk(16'h0800, 8'h11, SRC, XLATE_UCAST, 16'h2710);
            fwd(M0, 4'h3, G0);
            @(posedge CORE_CLK);
            UNICAST_METHOD <= 2'd0;
            mk(16'h0800, 8'h11, SRC, 32'h0A000007, 16'h2710);
            drop;
            @(posedge CORE_CLK);
            UNICAST_METHOD <= 2'd3;
            mk(16'h0800, 8'h11, SRC, 32'h0A000007, 16'h2710);
            fwd(48'h010000000007, 4'h2, 32'h0A000007);
        end
    endtask
    initial begin
        repeat (16) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        t_map;
        repeat (300) @(posedge CORE_CLK);
        t_fwd;
        t_filt;
        t_src;
        t_xlate;
        summarize;
    end
    initial begin
        #200000;
        err_total = err_total + 1;
        summarize;
    end
endmodule
